/* File: sub_swap_xor_regs.vh */
// constants for the subtract / swap / xor / direction-load execution block
// assumes it is included by bare name from the block's design file
`ifndef SUB_SWAP_XOR_REGS_VH
`define SUB_SWAP_XOR_REGS_VH

// ----------------------------------------------------------------
// software port map (8-bit address)
// ----------------------------------------------------------------
`define FILE_SPACE_BIT      7          // address bit 7 low: file space
`define WORK_REG_ADDR       8'h80      // working register
`define FLAGS_REG_ADDR      8'h81      // carry, digit carry, zero
`define EXEC_STAT_ADDR      8'h82      // execution state, read only

// ----------------------------------------------------------------
// flag layout and reset values
// ----------------------------------------------------------------
`define CARRY_BIT           0
`define DIGIT_CARRY_BIT     1
`define ZERO_BIT            2
`define FLAGS_WIDTH         3
`define FLAGS_RESET         3'h0
`define WORK_RESET          8'h00
`define DIR_RESET           8'hFF      // all port pins inputs after reset

// ----------------------------------------------------------------
// file addresses of the port-direction registers
// ----------------------------------------------------------------
`define DIR_FIRST_ADDR      7'h05
`define DIR_LAST_ADDR       7'h07

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define OP_SUB_W_FROM_FILE  6'h02      // 00 0010 dfff ffff
`define OP_XOR_WORK_FILE    6'h06      // 00 0110 dfff ffff
`define OP_SWAP_NIBBLES     6'h0E      // 00 1110 dfff ffff
`define OP_XOR_LITERAL      6'h3A      // 11 1010 kkkk kkkk
`define DIR_LOAD_PREFIX     11'h00C    // 00 0000 0110 0fff
`define DEST_BIT            7

// ----------------------------------------------------------------
// timing: one instruction cycle is four phases
// ----------------------------------------------------------------
`define PHASES_PER_CYCLE    4

`endif

/* File: sub_swap_xor_exec.v */
// execution datapath for subtract, nibble swap, xor and direction load
// assumes instruction words come from logic on the same clock, one at a time
// Function
// - subtract working register from file register, two's complement, update carry, digit carry, zero
// - carry set when difference non-negative (inverted borrow); zero only when difference zero
// - nibble swap exchanges file register halves, flags untouched
// - xor literal into working register, only zero flag changes
// - xor working register with file register, only zero flag changes
// - destination bit 0 writes working register, 1 writes file register
// - direction load copies working register to direction register 5..7, flags untouched
// - direction registers also reachable through ordinary file addressing
`timescale 1ns/1ns
`default_nettype none
`include "sub_swap_xor_regs.vh"

module sub_swap_xor_exec
(
    // clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // instruction stream
    input  wire [13:0] instr_word,
    input  wire        instr_valid,
    output reg         instr_ready_reg,
    output reg         instr_done_reg,
    output reg         instr_unknown_reg,
    // software register port
    input  wire [7:0]  sw_addr,
    input  wire [7:0]  sw_wdata,
    input  wire        sw_write,
    input  wire        sw_read,
    output reg  [7:0]  sw_rdata_reg,
    // port direction outputs, 1 = input
    output reg  [7:0]  dir_a_reg,
    output reg  [7:0]  dir_b_reg,
    output reg  [7:0]  dir_c_reg
);

    // ------------------------------------------------------------
    // phase states, one-hot
    // ------------------------------------------------------------
    localparam [4:0] ST_IDLE   = 5'h01;
    localparam [4:0] ST_DECODE = 5'h02;
    localparam [4:0] ST_READ   = 5'h04;
    localparam [4:0] ST_PROC   = 5'h08;
    localparam [4:0] ST_WRITE  = 5'h10;

    // kinds of decoded instruction
    localparam [2:0] K_NONE = 3'h0;
    localparam [2:0] K_SUB  = 3'h1;
    localparam [2:0] K_SWAP = 3'h2;
    localparam [2:0] K_XORL = 3'h3;
    localparam [2:0] K_XORF = 3'h4;
    localparam [2:0] K_DIR  = 3'h5;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true when a file address selects a direction register
    function is_dir_addr;
        input [6:0] a;
        begin
            is_dir_addr = (a >= `DIR_FIRST_ADDR) && (a <= `DIR_LAST_ADDR);
        end
    endfunction

    // value of a direction register picked by file address
    function [7:0] dir_value;
        input [6:0] a;
        input [7:0] da;
        input [7:0] db;
        input [7:0] dc;
        begin
            case (a[1:0])
                2'h1:    dir_value = da;
                2'h2:    dir_value = db;
                default: dir_value = dc;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg  [7:0]  file_mem [0:127];
    reg  [4:0]  state_reg;
    reg  [4:0]  state_next;
    reg  [13:0] ir_reg;
    reg  [2:0]  kind_reg;
    reg  [7:0]  operand_reg;
    reg  [7:0]  result_reg;
    reg  [2:0]  flags_reg;
    reg  [2:0]  flags_next_reg;
    reg  [7:0]  work_reg;

    wire [6:0]  ir_file   = ir_reg[6:0];
    wire        ir_dest   = ir_reg[`DEST_BIT];
    wire        in_write  = state_reg[4];

    // ------------------------------------------------------------
    // decode of the held instruction word
    // ------------------------------------------------------------
    reg  [2:0]  kind_next;
    always @*
    begin
        kind_next = K_NONE;
        if (ir_reg[13:3] == `DIR_LOAD_PREFIX && ir_reg[2:0] >= 3'h5)
            kind_next = K_DIR;
        else
            case (ir_reg[13:8])
                `OP_SUB_W_FROM_FILE: kind_next = K_SUB;
                `OP_SWAP_NIBBLES:    kind_next = K_SWAP;
                `OP_XOR_LITERAL:     kind_next = K_XORL;
                `OP_XOR_WORK_FILE:   kind_next = K_XORF;
                default:             kind_next = K_NONE;
            endcase
    end

    // ------------------------------------------------------------
    // operand read: literal, direction register or file memory
    // ------------------------------------------------------------
    reg  [7:0]  operand_next;
    always @*
    begin
        if (kind_reg == K_XORL)
            operand_next = ir_reg[7:0];
        else if (is_dir_addr(ir_file))
            operand_next = dir_value(ir_file, dir_a_reg, dir_b_reg, dir_c_reg);
        else
            operand_next = file_mem[ir_file];
    end

    // ------------------------------------------------------------
    // arithmetic and logic
    // ------------------------------------------------------------
    // nine and five bit differences give the borrows in their top bits, inverted for the carries
    wire [8:0]  diff_full = {1'b0, operand_reg} - {1'b0, work_reg};
    wire [4:0]  diff_low  = {1'b0, operand_reg[3:0]} - {1'b0, work_reg[3:0]};
    reg  [7:0]  result_next;
    reg  [2:0]  flags_calc;
    always @*
    begin
        result_next = 8'h00;
        flags_calc  = flags_reg;
        case (kind_reg)
            K_SUB:
            begin
                result_next = diff_full[7:0];
                flags_calc[`CARRY_BIT]       = ~diff_full[8];
                flags_calc[`DIGIT_CARRY_BIT] = ~diff_low[4];
                flags_calc[`ZERO_BIT]        = (diff_full[7:0] == 8'h00);
            end
            K_SWAP:
                result_next = {operand_reg[3:0], operand_reg[7:4]};
            K_XORL, K_XORF:
            begin
                result_next = work_reg ^ operand_reg;
                flags_calc[`ZERO_BIT] = (result_next == 8'h00);
            end
            K_DIR:
                result_next = work_reg;
            default:
                result_next = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // destination selection in the write phase
    // ------------------------------------------------------------
    wire to_work = in_write && (kind_reg == K_XORL ||
                   ((kind_reg == K_SUB || kind_reg == K_SWAP || kind_reg == K_XORF) && !ir_dest));
    wire to_file = in_write && (kind_reg == K_SUB || kind_reg == K_SWAP || kind_reg == K_XORF)
                   && ir_dest;
    wire to_dir  = in_write && kind_reg == K_DIR;
    wire [6:0] dst_addr = to_dir ? {4'h0, ir_reg[2:0]} : ir_file;
    wire       dst_dir  = to_dir || (to_file && is_dir_addr(ir_file));
    wire       dst_mem  = to_file && !is_dir_addr(ir_file);

    // software writes, instruction write phase wins on a clash
    wire sw_file  = sw_write && !sw_addr[`FILE_SPACE_BIT];
    wire sw_dir   = sw_file && is_dir_addr(sw_addr[6:0]);
    wire sw_work  = sw_write && sw_addr == `WORK_REG_ADDR && !to_work;
    wire sw_flags = sw_write && sw_addr == `FLAGS_REG_ADDR && !in_write;

    // ------------------------------------------------------------
    // phase sequencer: four phases per instruction
    // ------------------------------------------------------------
    always @*
    begin
        case (state_reg)
            ST_IDLE:   state_next = instr_valid ? ST_DECODE : ST_IDLE;
            ST_DECODE: state_next = ST_READ;
            ST_READ:   state_next = ST_PROC;
            ST_PROC:   state_next = ST_WRITE;
            ST_WRITE:  state_next = instr_valid ? ST_DECODE : ST_IDLE;
            default:   state_next = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // control and datapath registers
    // ------------------------------------------------------------
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg         <= ST_IDLE;
            ir_reg            <= 14'h0000;
            kind_reg          <= K_NONE;
            operand_reg       <= 8'h00;
            result_reg        <= 8'h00;
            flags_next_reg    <= `FLAGS_RESET;
            instr_ready_reg   <= 1'b1;
            instr_done_reg    <= 1'b0;
            instr_unknown_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            // word taken while ready and valid
            if (instr_ready_reg && instr_valid)
                ir_reg <= instr_word;
            if (state_reg[1])
                kind_reg <= kind_next;
            if (state_reg[2])
                operand_reg <= operand_next;
            if (state_reg[3])
            begin
                result_reg     <= result_next;
                flags_next_reg <= flags_calc;
            end
            instr_ready_reg   <= (state_next == ST_IDLE) || (state_next == ST_WRITE);
            instr_done_reg    <= in_write;
            instr_unknown_reg <= state_reg[1] && kind_next == K_NONE;
        end
    end

    // ------------------------------------------------------------
    // working register and flags
    // ------------------------------------------------------------
    // swap and direction load leave flags alone by keeping flags_calc
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            work_reg  <= `WORK_RESET;
            flags_reg <= `FLAGS_RESET;
        end
        else
        begin
            if (to_work)
                work_reg <= result_reg;
            else if (sw_work)
                work_reg <= sw_wdata;
            if (in_write)
                flags_reg <= flags_next_reg;
            else if (sw_flags)
                flags_reg <= sw_wdata[`FLAGS_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // port direction registers
    // ------------------------------------------------------------
    wire [6:0] dir_sel = dst_dir ? dst_addr : sw_addr[6:0];
    wire [7:0] dir_val = dst_dir ? result_reg : sw_wdata;
    wire       dir_we  = dst_dir || sw_dir;
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir_a_reg <= `DIR_RESET;
            dir_b_reg <= `DIR_RESET;
            dir_c_reg <= `DIR_RESET;
        end
        else if (dir_we)
        begin
            case (dir_sel[1:0])
                2'h1:    dir_a_reg <= dir_val;
                2'h2:    dir_b_reg <= dir_val;
                default: dir_c_reg <= dir_val;
            endcase
        end
    end

    // ------------------------------------------------------------
    // general file memory, no reset on the array
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        if (dst_mem)
            file_mem[ir_file] <= result_reg;
        else if (sw_file && !sw_dir)
            file_mem[sw_addr[6:0]] <= sw_wdata;
    end

    // ------------------------------------------------------------
    // software read data, valid the cycle after the strobe
    // ------------------------------------------------------------
    reg [7:0] rdata_next;
    always @*
    begin
        rdata_next = 8'h00;
        if (!sw_addr[`FILE_SPACE_BIT])
            rdata_next = is_dir_addr(sw_addr[6:0]) ?
                         dir_value(sw_addr[6:0], dir_a_reg, dir_b_reg, dir_c_reg) :
                         file_mem[sw_addr[6:0]];
        else if (sw_addr == `WORK_REG_ADDR)
            rdata_next = work_reg;
        else if (sw_addr == `FLAGS_REG_ADDR)
            rdata_next = {5'h00, flags_reg};
        else if (sw_addr == `EXEC_STAT_ADDR)
            rdata_next = {3'h0, state_reg};
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sw_rdata_reg <= 8'h00;
        else if (sw_read)
            sw_rdata_reg <= rdata_next;
        else
            sw_rdata_reg <= 8'h00;                // zero outside a read answer
    end

endmodule // sub_swap_xor_exec

`default_nettype wire

/* File: sub_swap_xor_properties.sv */
// port assertions for the subtract / swap / xor execution block
// assumes bind onto sub_swap_xor_exec, single clock domain
`timescale 1ns/1ns
`default_nettype none
`include "sub_swap_xor_regs.vh"
module sub_swap_xor_checker
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // instruction stream
    input wire logic [13:0] instr_word,
    input wire logic        instr_valid,
    input wire logic        instr_ready_reg,
    input wire logic        instr_done_reg,
    input wire logic        instr_unknown_reg,
    // software port
    input wire logic [7:0]  sw_addr,
    input wire logic        sw_write,
    input wire logic        sw_read,
    input wire logic [7:0]  sw_rdata_reg,
    // direction outputs
    input wire logic [7:0]  dir_a_reg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ----------------------------
    // decode helpers
    // ----------------------------
    wire take  = instr_valid && instr_ready_reg;
    wire legal = (instr_word[13:8] == `OP_SUB_W_FROM_FILE) || (instr_word[13:8] == `OP_XOR_WORK_FILE)
              || (instr_word[13:8] == `OP_SWAP_NIBBLES) || (instr_word[13:8] == `OP_XOR_LITERAL)
              || ((instr_word[13:3] == `DIR_LOAD_PREFIX) && (instr_word[2:0] >= 3'h5));
    // ----------------------------
    // instruction timing
    // ----------------------------
    AST_DONE_LATENCY: assert property (take |-> ##5 instr_done_reg)
        else $error("done not five cycles after take");
    AST_READY_GAP: assert property (take |=> !instr_ready_reg [*3] ##1 instr_ready_reg)
        else $error("ready gap not three cycles");
    AST_DONE_CAUSE: assert property (instr_done_reg |-> $past(instr_ready_reg) && !$past(instr_ready_reg, 2))
        else $error("done without a write phase");
    AST_DONE_PULSE: assert property (instr_done_reg |=> !instr_done_reg)
        else $error("done longer than one cycle");
    AST_UNK_FROM_BAD: assert property (instr_unknown_reg |-> $past(take, 2) && !$past(legal, 2))
        else $error("unknown flagged for a valid word");
    AST_BAD_FLAGGED: assert property (take && !legal |-> ##2 instr_unknown_reg)
        else $error("bad word not flagged");
    // ----------------------------
    // direction register and read port
    // ----------------------------
    AST_DIR_CAUSE: assert property ($changed(dir_a_reg) |->
            $past(sw_write) || ($past(instr_ready_reg) && !$past(instr_ready_reg, 2)))
        else $error("direction changed without a cause");
    AST_RDATA_IDLE: assert property (!sw_read |=> sw_rdata_reg == 8'h00)
        else $error("read data not zero outside a read");
    AST_RDATA_DIR: assert property (sw_read && sw_addr == 8'h05 |=> sw_rdata_reg == $past(dir_a_reg))
        else $error("direction read mismatch");
endmodule // sub_swap_xor_checker
bind sub_swap_xor_exec sub_swap_xor_checker chk (.clock(clock), .rst_n(rst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready_reg(instr_ready_reg), .instr_done_reg(instr_done_reg),
    .instr_unknown_reg(instr_unknown_reg), .sw_addr(sw_addr), .sw_write(sw_write), .sw_read(sw_read),
    .sw_rdata_reg(sw_rdata_reg), .dir_a_reg(dir_a_reg));
`default_nettype wire

/* File: prog_word_source.sv */
// program memory model offering instruction words one at a time
// assumes the block takes a word at an edge with valid and ready high
`timescale 1ns/1ns
`default_nettype none
module prog_word_source
(
    // clock
    input  wire logic        clock,
    // instruction stream
    input  wire logic        instr_ready_reg,
    output var  logic [13:0] instr_word,
    output var  logic        instr_valid
);
    // idle bus at time zero
    initial
    begin
        instr_valid = 1'b0;
        instr_word  = 14'h0000;
    end
    // offer one word, held until taken or for 16 edges at most; idle word toggles so stale data never looks valid
    // direction load is sent only when a caller asks for it
    task offer(input logic [13:0] word, input int idle);
        int n;
        for (n = 0; n < idle; n++)
        begin
            @(posedge clock);
            instr_word <= ~instr_word;
        end
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word  <= word; // one word per instruction
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (instr_ready_reg !== 1'b1 && n < 16);
        instr_valid <= 1'b0;
        instr_word  <= ~word;
    endtask
endmodule // prog_word_source
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the execution block
// assumes design, checker and program-memory model are compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "sub_swap_xor_regs.vh"
module tb;
    logic        clock;
    logic        rst_n;
    logic [13:0] instr_word;
    logic        instr_valid, instr_ready_reg, instr_done_reg, instr_unknown_reg;
    logic [7:0]  sw_addr, sw_wdata, sw_rdata_reg, dir_a_reg, dir_b_reg, dir_c_reg, rd, f, w, res;
    logic        sw_write, sw_read;
    logic        unk_seen;
    int          bad_count, tests_run, cycles, i;
    sub_swap_xor_exec sub_swap_xor_exec_inst (.clock(clock), .rst_n(rst_n), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_ready_reg(instr_ready_reg), .instr_done_reg(instr_done_reg),
        .instr_unknown_reg(instr_unknown_reg), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
        .sw_read(sw_read), .sw_rdata_reg(sw_rdata_reg), .dir_a_reg(dir_a_reg), .dir_b_reg(dir_b_reg),
        .dir_c_reg(dir_c_reg));
    prog_word_source prog_word_source_inst (.clock(clock), .instr_ready_reg(instr_ready_reg),
        .instr_word(instr_word), .instr_valid(instr_valid));
    // ----------------------------
    // shared tasks
    // ----------------------------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task sw_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sw_write <= 1'b1; sw_addr <= a; sw_wdata <= d;
        @(posedge clock);
        sw_write <= 1'b0;
    endtask
    task sw_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        sw_read <= 1'b1; sw_addr <= a;
        @(posedge clock);
        sw_read <= 1'b0;
        #1 d = sw_rdata_reg; // read data stand only in this cycle
    endtask
    task exec(input logic [13:0] word);
        int n;
        prog_word_source_inst.offer(word, 0);
        n = 0;
        unk_seen = 1'b0;
        while (instr_done_reg !== 1'b1 && n < 8)
        begin
            @(posedge clock);
            #1 n++;
            if (instr_unknown_reg === 1'b1) unk_seen = 1'b1; // pulse stands one cycle after decode
        end
        check(8'(n), 8'h04);
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------
    // scenarios
    // ----------------------------
    task test_reset;
        sw_rd(`WORK_REG_ADDR, rd); check(rd, `WORK_RESET);
        sw_rd(`FLAGS_REG_ADDR, rd); check(rd, {5'h00, `FLAGS_RESET});
        sw_rd(`EXEC_STAT_ADDR, rd); check(rd, 8'h01);
        for (i = 0; i < 3; i++)
        begin
            sw_rd(8'h05 + 8'(i), rd); check(rd, `DIR_RESET);
        end
        sw_wr(8'h90, 8'h5A); sw_rd(8'h90, rd); check(rd, 8'h00); // unmapped place reads zero
        $display("test reset done");
    endtask
    task test_sub;
        logic [7:0] ft [4] = '{8'h03, 8'h02, 8'h01, 8'h10};
        logic [7:0] wt [4] = '{8'h02, 8'h02, 8'h02, 8'h01};
        for (i = 0; i < 4; i++)
        begin
            f = ft[i]; w = wt[i]; res = f - w;
            sw_wr(8'h20, f); sw_wr(`WORK_REG_ADDR, w);
            exec({`OP_SUB_W_FROM_FILE, i < 3, 7'h20});
            sw_rd(8'h20, rd); check(rd, (i < 3) ? res : f);
            sw_rd(`WORK_REG_ADDR, rd); check(rd, (i < 3) ? w : res);
            sw_rd(`FLAGS_REG_ADDR, rd); check(rd, {5'h00, res == 8'h00, f[3:0] >= w[3:0], f >= w});
        end
        $display("test subtract done");
    endtask
    task test_swap;
        sw_wr(8'h21, 8'hA5); sw_wr(`FLAGS_REG_ADDR, 8'h07);
        exec({`OP_SWAP_NIBBLES, 1'b0, 7'h21});
        sw_rd(`WORK_REG_ADDR, rd); check(rd, 8'h5A);
        sw_rd(8'h21, rd); check(rd, 8'hA5);
        exec({`OP_SWAP_NIBBLES, 1'b1, 7'h21});
        sw_rd(8'h21, rd); check(rd, 8'h5A);
        sw_rd(`FLAGS_REG_ADDR, rd); check(rd, 8'h07);
        $display("test swap done");
    endtask
    task test_xor;
        sw_wr(`WORK_REG_ADDR, 8'hB5); sw_wr(`FLAGS_REG_ADDR, 8'h03);
        exec({`OP_XOR_LITERAL, 8'hAF});
        sw_rd(`WORK_REG_ADDR, rd); check(rd, 8'h1A);
        sw_rd(`FLAGS_REG_ADDR, rd); check(rd, 8'h03);
        exec({`OP_XOR_LITERAL, 8'h1A});
        sw_rd(`FLAGS_REG_ADDR, rd); check(rd, 8'h07);
        sw_wr(8'h22, 8'hAF); sw_wr(`WORK_REG_ADDR, 8'hB5);
        exec({`OP_XOR_WORK_FILE, 1'b1, 7'h22});
        sw_rd(8'h22, rd); check(rd, 8'h1A);
        sw_rd(`WORK_REG_ADDR, rd); check(rd, 8'hB5);
        sw_rd(`FLAGS_REG_ADDR, rd); check(rd, 8'h03);
        $display("test xor done");
    endtask
    task test_dir;
        for (i = 0; i < 3; i++)
        begin
            sw_wr(`WORK_REG_ADDR, 8'h30 + 8'(i)); sw_wr(`FLAGS_REG_ADDR, 8'h05);
            exec({`DIR_LOAD_PREFIX, 3'h5 + 3'(i)});
            check(8'({dir_c_reg, dir_b_reg, dir_a_reg} >> (8 * i)), 8'h30 + 8'(i));
            check(8'(unk_seen), 8'h00);
            sw_rd(`FLAGS_REG_ADDR, rd); check(rd, 8'h05);
        end
        exec({`DIR_LOAD_PREFIX, 3'h4}); // out-of-range operand has no effect
        check(dir_a_reg, 8'h30);
        check(8'(unk_seen), 8'h01);
        sw_wr(8'h06, 8'hC3);
        #1 check(dir_b_reg, 8'hC3); // look after the writing edge has settled
        sw_rd(8'h06, rd); check(rd, 8'hC3);
        $display("test direction done");
    endtask
    task test_b2b;
        sw_wr(`WORK_REG_ADDR, 8'h00);
        prog_word_source_inst.offer({`OP_XOR_LITERAL, 8'h0F}, 0);
        prog_word_source_inst.offer({`OP_XOR_LITERAL, 8'hF0}, 0);
        prog_word_source_inst.offer({`OP_XOR_LITERAL, 8'h3C}, 3); // slow source
        repeat (5) @(posedge clock);
        sw_rd(`WORK_REG_ADDR, rd); check(rd, 8'hC3);
        $display("test back to back done");
    endtask
    // ----------------------------
    // clock, timeout, main sequence
    // ----------------------------
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard, far above the expected few hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            wrap_up;
        end
    end
    initial
    begin
        rst_n = 1'b0; sw_addr = 8'h00; sw_wdata = 8'h00; sw_write = 1'b0; sw_read = 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        test_reset;
        test_sub;
        test_swap;
        test_xor;
        test_dir;
        test_b2b;
        wrap_up;
    end
endmodule // tb
`default_nettype wire
